// *** hdl/annunciator_params.svh ***
// offsets, field positions, sizes and timing counts of the annunciator
// assumes inclusion by bare name from every file that needs a number
`ifndef ANNUNCIATOR_PARAMS_SVH
`define ANNUNCIATOR_PARAMS_SVH

// clock rate and stop indicator blink timing
`define CLK_HZ             25000000
`define BLINK_HALF_MS      250
`define BLINK_HALF_CYCLES  ((`CLK_HZ / 1000) * `BLINK_HALF_MS)

// sizes
`define FAULT_SLOTS        16
`define FAULT_CODE_W       16
`define WARN_BITS_DEFAULT  128
`define LIST_LEN           8
`define LIST_CNT_W         4

// byte offsets of the register map
`define OFS_STATUS         8'h00
`define OFS_ERROR_WORD     8'h04
`define OFS_WARNING_WORD   8'h08
`define OFS_LIST_COUNT     8'h0c
`define OFS_IRQ_STATUS     8'h10
`define OFS_IRQ_CLEAR      8'h14
`define OFS_IRQ_ENABLE     8'h18
`define OFS_FAULT_BASE     8'h40
`define OFS_WARN_BASE      8'h80
`define OFS_LIST_BASE      8'hc0

// region codes on address bits 7:6
`define REGION_FAULT       2'h1
`define REGION_WARN        2'h2
`define REGION_LIST        2'h3

// status register fields
`define ST_FAULT_ANNUN     0
`define ST_WARN_ANNUN      1
`define ST_BUSY            2
`define ST_OUTPUTS_OFF     3

// interrupt event fields
`define IRQ_W              4
`define EV_FAULT           0
`define EV_WARN_RAISE      1
`define EV_WARN_CLEAR      2
`define EV_LIST_DROP       3

`endif

// *** hdl/annunciator_pkg.sv ***
// types shared by the annunciator files
// assumes the numbers themselves come from annunciator_params.svh
package annunciator_pkg;

    // warning list update sequencer
    typedef enum logic [1:0] {
        WL_IDLE    = 2'b00,
        WL_COMPACT = 2'b01,
        WL_APPEND  = 2'b10
    } wl_state_t;

endpackage

// *** hdl/fault_code_check.sv ***
// or-reduction of the fatal fault code slots
// assumes codes arrive flattened, slot 0 in the low bits, same clock domain
`timescale 1ns/1ps
`include "annunciator_params.svh"

module fault_code_check #(
    parameter int SLOTS  = `FAULT_SLOTS,
    parameter int CODE_W = `FAULT_CODE_W
) (
    // flattened slot contents
    input  wire logic [SLOTS*CODE_W-1:0] codes_in,
    // high while any slot holds a non-zero code
    output logic                         any_out
);
    logic [SLOTS-1:0] slot_set;  // per-slot non-zero flag

    // one comparator per slot
    genvar s;
    generate
        for (s = 0; s < SLOTS; s++) begin : g_slot
            assign slot_set[s] = |codes_in[s*CODE_W +: CODE_W];
        end
    endgenerate

    // combinational so a code written just before scan end is seen
    assign any_out = |slot_set;
endmodule

// *** hdl/stop_blinker.sv ***
// stop indicator flasher driven by a half-period divider
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
`include "annunciator_params.svh"

module stop_blinker #(
    parameter int HALF_CYCLES = `BLINK_HALF_CYCLES
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // blink request
    input  wire logic enable_in,
    // indicator drive
    output logic      led_out
);
    logic [31:0] div;       // half-period counter
    logic [31:0] next_div;
    logic        next_led;

    // count up, toggle at HALF_CYCLES - 1 and restart from zero; dark when not enabled
    always_comb begin
        next_div = div;
        next_led = led_out;
        if (!enable_in) begin
            next_div = 32'h0;
            next_led = 1'b0;
        end else if (div >= 32'(HALF_CYCLES - 1)) begin
            next_div = 32'h0;
            next_led = ~led_out;
        end else begin
            next_div = div + 32'h1;
        end
    end

    // register divider and lamp
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            div     <= 32'h0;
            led_out <= 1'b0;
        end else begin
            div     <= next_div;
            led_out <= next_led;
        end
    end
endmodule

// *** hdl/external_fault_annunciator.sv ***
// external device fault annunciator: fault code slots, warning bits,
// ordered warning list, stop latch, interrupt and avalon register slave
// assumes scan_done_in is a one-cycle pulse from logic on clk_in
// Contract
// - scan end checks slots, sets fault annunciation
// - fatal fault forces outputs off, stops
// - warnings alone never stop scanning
// - scan end checks warning bits, raises annunciation
// - eight-entry list by occurrence, unused zero
// - old entries stay low, new appended ascending
// - full list records no further warnings
// - released entry removed, later shift, refill top
// - all released clears warning annunciation
// - any annunciation blinks stop indicator
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`include "annunciator_params.svh"

module external_fault_annunciator #(
    parameter int WARN_BITS   = `WARN_BITS_DEFAULT,
    parameter int BLINK_HALF  = `BLINK_HALF_CYCLES
) (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // program scan
    input  wire logic        scan_done_in,
    output logic             run_out,
    output logic             outputs_off_out,
    output logic             update_busy_out,
    // annunciation
    output logic             fault_annunciation_bit_out,
    output logic             warning_annunciation_bit_out,
    output logic             stop_led_out,
    output logic             irq_out,
    // avalon-mm slave
    input  wire logic [7:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out
);
    localparam int IDX_W   = $clog2(WARN_BITS);
    localparam int WORDS   = WARN_BITS / 32;
    localparam int SLOTS   = `FAULT_SLOTS;
    localparam int CODE_W  = `FAULT_CODE_W;
    localparam int LEN     = `LIST_LEN;
    localparam int CNT_W   = `LIST_CNT_W;

    // software-written storage
    logic [CODE_W-1:0]       ext_fault_code [SLOTS];      // fatal code slots
    logic [CODE_W-1:0]       next_fault_code [SLOTS];
    logic [WARN_BITS-1:0]    ext_warn_bit;                // warning bit array
    logic [WARN_BITS-1:0]    next_warn_bit;
    logic [`IRQ_W-1:0]       irq_enable;                  // interrupt mask
    logic [`IRQ_W-1:0]       next_irq_enable;
    // bus handshake
    logic                    ack;                         // answer phase
    logic                    next_ack;
    logic [31:0]             rd_value;                    // decoded read
    logic [31:0]             next_readdata;
    logic                    wr_fire;                     // write commit
    // fatal latch
    logic                    fatal;                       // stopped by fault
    logic                    next_fatal;
    logic                    fault_any;                   // any slot non-zero
    logic [SLOTS*CODE_W-1:0] codes_flat;
    // warning list
    annunciator_pkg::wl_state_t wl_state;
    annunciator_pkg::wl_state_t next_wl_state;
    logic [IDX_W-1:0]        ext_warn_list [LEN];         // listed indices
    logic [IDX_W-1:0]        next_list [LEN];
    logic [CNT_W-1:0]        list_count;                  // entries in use
    logic [CNT_W-1:0]        next_count;
    logic [WARN_BITS-1:0]    listed;                      // index already listed
    logic [WARN_BITS-1:0]    next_listed;
    logic [WARN_BITS-1:0]    snap;                        // bits at scan end
    logic [WARN_BITS-1:0]    next_snap;
    logic [IDX_W-1:0]        idx;                         // append cursor
    logic [IDX_W-1:0]        next_idx;
    logic                    warn_annun;
    logic                    next_warn_annun;
    logic [CNT_W-1:0]        wp;                          // compaction pointer
    // events and interrupt status
    logic [`IRQ_W-1:0]       events;
    logic [`IRQ_W-1:0]       irq_status;
    logic [`IRQ_W-1:0]       next_irq_status;
    logic                    fault_event;
    logic                    ev_raise;
    logic                    ev_clear;
    logic                    ev_drop;

    // merge a bus word into old contents under byte enables
    function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // slot comparators
    genvar g;
    generate
        for (g = 0; g < SLOTS; g++) begin : g_flat
            assign codes_flat[g*CODE_W +: CODE_W] = ext_fault_code[g];
        end
    endgenerate

    fault_code_check #(
        .SLOTS  (SLOTS),
        .CODE_W (CODE_W)
    ) u_check (
        .codes_in (codes_flat),
        .any_out  (fault_any)
    );

    // blink while either representative word holds a fault
    stop_blinker #(
        .HALF_CYCLES (BLINK_HALF)
    ) u_blink (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .enable_in (fatal | warn_annun),
        .led_out   (stop_led_out)
    );

    // bus: wait one cycle, answer on the second edge
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack;
    assign wr_fire             = avs_write_in & ack;

    // read decode
    always_comb begin
        rd_value = 32'h0;
        case (avs_address_in[7:6])
            `REGION_FAULT: begin
                rd_value = 32'(ext_fault_code[avs_address_in[5:2]]);
            end
            `REGION_WARN: begin
                if (32'(avs_address_in[5:2]) < 32'(WORDS)) begin
                    rd_value = ext_warn_bit[avs_address_in[5:2]*32 +: 32];
                end
            end
            `REGION_LIST: begin
                if (!avs_address_in[5]) begin
                    rd_value = 32'(ext_warn_list[avs_address_in[4:2]]);
                end
            end
            default: begin
                case (avs_address_in)
                    `OFS_STATUS: begin
                        rd_value[`ST_FAULT_ANNUN] = fatal;
                        rd_value[`ST_WARN_ANNUN]  = warn_annun;
                        rd_value[`ST_BUSY]        = update_busy_out;
                        rd_value[`ST_OUTPUTS_OFF] = fatal;
                    end
                    `OFS_ERROR_WORD:   rd_value[`ST_FAULT_ANNUN] = fatal;
                    `OFS_WARNING_WORD: rd_value[`ST_WARN_ANNUN]  = warn_annun;
                    `OFS_LIST_COUNT:   rd_value = 32'(list_count);
                    `OFS_IRQ_STATUS:   rd_value = 32'(irq_status);
                    `OFS_IRQ_ENABLE:   rd_value = 32'(irq_enable);
                    default:           rd_value = 32'h0;  // unmapped reads zero
                endcase
            end
        endcase
    end

    // bus writes and handshake next values
    always_comb begin
        next_ack        = (avs_read_in | avs_write_in) & ~ack;
        next_readdata   = avs_readdata_out;
        next_fault_code = ext_fault_code;
        next_warn_bit   = ext_warn_bit;
        next_irq_enable = irq_enable;
        if ((avs_read_in | avs_write_in) && !ack) begin
            next_readdata = rd_value;
        end
        if (wr_fire) begin
            case (avs_address_in[7:6])
                `REGION_FAULT: begin
                    next_fault_code[avs_address_in[5:2]] = CODE_W'(merge_be(
                        32'(ext_fault_code[avs_address_in[5:2]]),
                        avs_writedata_in, avs_byteenable_in));
                end
                `REGION_WARN: begin
                    for (int w = 0; w < WORDS; w++) begin
                        if (32'(avs_address_in[5:2]) == 32'(w)) begin
                            next_warn_bit[w*32 +: 32] = merge_be(ext_warn_bit[w*32 +: 32],
                                avs_writedata_in, avs_byteenable_in);
                        end
                    end
                end
                default: begin
                    if (avs_address_in == `OFS_IRQ_ENABLE && avs_byteenable_in[0]) begin
                        next_irq_enable = avs_writedata_in[`IRQ_W-1:0];
                    end
                end
            endcase
        end
    end

    // register bus storage
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ack              <= 1'b0;
            avs_readdata_out <= 32'h0;
            ext_fault_code   <= '{default: '0};
            ext_warn_bit     <= '0;
            irq_enable       <= '0;
        end else begin
            ack              <= next_ack;
            avs_readdata_out <= next_readdata;
            ext_fault_code   <= next_fault_code;
            ext_warn_bit     <= next_warn_bit;
            irq_enable       <= next_irq_enable;
        end
    end

    // fatal latch: set at scan end, only reset clears it
    always_comb begin
        fault_event = scan_done_in & ~fatal & fault_any;
        next_fatal  = fatal | fault_event;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            fatal <= 1'b0;
        end else begin
            fatal <= next_fatal;
        end
    end

    assign fault_annunciation_bit_out   = fatal;
    assign outputs_off_out              = fatal;
    assign run_out                      = ~fatal;
    assign warning_annunciation_bit_out = warn_annun;
    assign update_busy_out              = (wl_state != annunciator_pkg::WL_IDLE);

    // warning list sequencer: snapshot, compact, append one index a cycle
    always_comb begin
        next_wl_state   = wl_state;
        next_list       = ext_warn_list;
        next_count      = list_count;
        next_listed     = listed;
        next_snap       = snap;
        next_idx        = idx;
        next_warn_annun = warn_annun;
        ev_raise        = 1'b0;
        ev_clear        = 1'b0;
        ev_drop         = 1'b0;
        wp              = '0;
        case (wl_state)
            annunciator_pkg::WL_IDLE: begin
                // warnings keep scanning; a fatal stop ends updates
                if (scan_done_in && !fatal && !fault_any) begin
                    next_snap     = ext_warn_bit;
                    next_wl_state = annunciator_pkg::WL_COMPACT;
                end
            end
            annunciator_pkg::WL_COMPACT: begin
                // drop released entries, survivors slide down in order
                for (int i = 0; i < LEN; i++) begin
                    next_list[i] = '0;
                end
                for (int i = 0; i < LEN; i++) begin
                    if (CNT_W'(i) < list_count) begin
                        if (snap[ext_warn_list[i]]) begin
                            next_list[wp[2:0]] = ext_warn_list[i];
                            wp = wp + CNT_W'(1);
                        end else begin
                            next_listed[ext_warn_list[i]] = 1'b0;
                        end
                    end
                end
                next_count    = wp;
                next_idx      = '0;
                next_wl_state = annunciator_pkg::WL_APPEND;
            end
            annunciator_pkg::WL_APPEND: begin
                // ascending scan appends newcomers behind older entries
                if (snap[idx] && !listed[idx]) begin
                    if (list_count < CNT_W'(LEN)) begin
                        next_list[list_count[2:0]] = idx;
                        next_listed[idx]           = 1'b1;
                        next_count                 = list_count + CNT_W'(1);
                    end else begin
                        ev_drop = 1'b1;
                    end
                end
                if (idx == IDX_W'(WARN_BITS - 1)) begin
                    next_warn_annun = (|snap) | (next_count != '0);
                    ev_raise        = next_warn_annun & ~warn_annun;
                    ev_clear        = ~next_warn_annun & warn_annun;
                    next_wl_state   = annunciator_pkg::WL_IDLE;
                end else begin
                    next_idx = idx + IDX_W'(1);
                end
            end
            default: begin
                next_wl_state = annunciator_pkg::WL_IDLE;
            end
        endcase
    end

    // register the list state
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wl_state      <= annunciator_pkg::WL_IDLE;
            ext_warn_list <= '{default: '0};
            list_count    <= '0;
            listed        <= '0;
            snap          <= '0;
            idx           <= '0;
            warn_annun    <= 1'b0;
        end else begin
            wl_state      <= next_wl_state;
            ext_warn_list <= next_list;
            list_count    <= next_count;
            listed        <= next_listed;
            snap          <= next_snap;
            idx           <= next_idx;
            warn_annun    <= next_warn_annun;
        end
    end

    // sticky interrupt status, a same-cycle event beats the clear
    always_comb begin
        events                 = '0;
        events[`EV_FAULT]      = fault_event;
        events[`EV_WARN_RAISE] = ev_raise;
        events[`EV_WARN_CLEAR] = ev_clear;
        events[`EV_LIST_DROP]  = ev_drop;
        next_irq_status        = irq_status;
        if (wr_fire && avs_address_in == `OFS_IRQ_CLEAR && avs_byteenable_in[0]) begin
            next_irq_status = irq_status & ~avs_writedata_in[`IRQ_W-1:0];
        end
        next_irq_status = next_irq_status | events;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            irq_status <= '0;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    assign irq_out = |(irq_status & irq_enable);
endmodule

// *** sim/external_fault_annunciator_sva.sv ***
// assertion checker for the external fault annunciator, top ports only
// assumes it is bound onto every external_fault_annunciator instance
`timescale 1ns/1ps
`include "annunciator_params.svh"

module external_fault_annunciator_sva #(
    parameter int WARN_BITS  = `WARN_BITS_DEFAULT,
    parameter int BLINK_HALF = `BLINK_HALF_CYCLES
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // scan and state
    input wire logic scan_done_in,
    input wire logic run_out,
    input wire logic outputs_off_out,
    input wire logic update_busy_out,
    // annunciation
    input wire logic fault_annunciation_bit_out,
    input wire logic warning_annunciation_bit_out,
    input wire logic stop_led_out
);
    logic [31:0] led_cnt;       // cycles the indicator has not changed while anything is annunciated
    logic [31:0] next_led_cnt;  // next value of led_cnt
    logic        led_prev;      // indicator one cycle ago
    logic [31:0] busy_cnt;      // length of the current busy run
    logic [31:0] next_busy_cnt; // next value of busy_cnt

    // next values of the helper counters
    always_comb begin
        next_led_cnt = led_cnt + 32'h1;
        // idle indicator or a fresh edge restarts the count
        if (!(fault_annunciation_bit_out || warning_annunciation_bit_out)
            || stop_led_out != led_prev) begin
            next_led_cnt = 32'h0;
        end
        next_busy_cnt = update_busy_out ? busy_cnt + 32'h1 : 32'h0;
    end

    // register the helper counters
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            led_cnt  <= 32'h0;
            led_prev <= 1'b0;
            busy_cnt <= 32'h0;
        end else begin
            led_cnt  <= next_led_cnt;
            led_prev <= stop_led_out;
            busy_cnt <= next_busy_cnt;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    chk_run_fatal: assert property (run_out != outputs_off_out)
        else $error("run and forced-off outputs disagree");
    chk_fatal_sticky: assert property (outputs_off_out |=> outputs_off_out)
        else $error("forced-off state left without reset");
    chk_fatal_cause: assert property ($rose(outputs_off_out) |-> $past(scan_done_in))
        else $error("outputs forced off away from a scan end");
    chk_fault_at_scan: assert property ($rose(fault_annunciation_bit_out) |-> $past(scan_done_in))
        else $error("fault annunciation rose away from a scan end");
    chk_warn_no_stop: assert property (!fault_annunciation_bit_out |-> run_out)
        else $error("halted without a fatal fault");
    chk_led_idle: assert property ((!fault_annunciation_bit_out && !warning_annunciation_bit_out)[*2]
        |-> !stop_led_out)
        else $error("stop indicator lit with nothing annunciated");
    chk_led_blinks: assert property (led_cnt <= BLINK_HALF + 2)
        else $error("stop indicator not blinking");
    chk_busy_cause: assert property ($rose(update_busy_out)
        |-> $past(scan_done_in) && !outputs_off_out)
        else $error("list update started without a running scan end");
    chk_busy_bound: assert property (busy_cnt <= WARN_BITS + 2)
        else $error("list update ran too long");
    chk_warn_at_end: assert property ($changed(warning_annunciation_bit_out)
        |-> $past(update_busy_out))
        else $error("warning annunciation changed outside a list update");
endmodule

bind external_fault_annunciator external_fault_annunciator_sva #(
    .WARN_BITS(WARN_BITS), .BLINK_HALF(BLINK_HALF)) u_sva (
    .clk_in(clk_in), .rst_in(rst_in), .scan_done_in(scan_done_in), .run_out(run_out),
    .outputs_off_out(outputs_off_out), .update_busy_out(update_busy_out),
    .fault_annunciation_bit_out(fault_annunciation_bit_out),
    .warning_annunciation_bit_out(warning_annunciation_bit_out), .stop_led_out(stop_led_out));

// *** sim/testbench.sv ***
// self-checking bench for the external fault annunciator
// assumes the checker is bound in by its own file
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
    $display("Error at %0t ns: got %h expected %h", $time, (got), (exp)); end end

module testbench;
    localparam int WARN_BITS  = 128; // warning array width
    localparam int BLINK_HALF = 4;   // short blink for simulation
    // stimulus
    logic        clk_in            = 1'b0;
    logic        rst_in            = 1'b1;
    logic        scan_done_in      = 1'b0;
    logic [7:0]  avs_address_in    = 8'h00;
    logic        avs_read_in       = 1'b0;
    logic        avs_write_in      = 1'b0;
    logic [31:0] avs_writedata_in  = 32'h0;
    logic [3:0]  avs_byteenable_in = 4'hf;
    // observed
    logic        run_out, outputs_off_out, update_busy_out, stop_led_out, irq_out;
    logic        fault_annunciation_bit_out, warning_annunciation_bit_out;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    // bookkeeping
    int          failures    = 0;
    int          check_count = 0;
    logic [31:0] rd;            // last read data

    external_fault_annunciator #(.WARN_BITS(WARN_BITS), .BLINK_HALF(BLINK_HALF)) u_dut (
        .clk_in(clk_in), .rst_in(rst_in), .scan_done_in(scan_done_in), .run_out(run_out),
        .outputs_off_out(outputs_off_out), .update_busy_out(update_busy_out),
        .fault_annunciation_bit_out(fault_annunciation_bit_out),
        .warning_annunciation_bit_out(warning_annunciation_bit_out),
        .stop_led_out(stop_led_out), .irq_out(irq_out), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out));

    // 25 MHz clock
    always #20 clk_in = ~clk_in;

    // one bus transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        avs_address_in   <= a;
        avs_writedata_in <= d;
        avs_write_in     <= wr;
        avs_read_in      <= !wr;
        // waitrequest and read data as they stood at each rising edge
        do begin
            @(posedge clk_in);
        end while (avs_waitrequest_out !== 1'b0);
        rd = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in  <= 1'b0;
    endtask

    // read and compare one register
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask

    // synchronous reset for three cycles
    task automatic do_reset();
        @(posedge clk_in);
        rst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
    endtask

    // one scan end pulse, then wait out the list update
    task automatic scan();
        int n;
        n = 0;
        @(posedge clk_in);
        scan_done_in <= 1'b1;
        @(posedge clk_in);
        scan_done_in <= 1'b0;
        @(negedge clk_in);
        while (update_busy_out === 1'b1 && n < 300) begin
            @(negedge clk_in);
            n++;
        end
        `CHK(update_busy_out, 1'b0)
    endtask

    // whole warning list and its count
    task automatic list_chk(input logic [31:0] e [8], input logic [31:0] cnt);
        for (int k = 0; k < 8; k++) begin
            rdchk(8'hc0 + 8'(4 * k), e[k]);
        end
        rdchk(8'h0c, cnt);
    endtask

    // indicator seen at both levels, or held low
    task automatic blink_chk(input logic on);
        logic [1:0] seen;
        seen = 2'b00;
        repeat (2 * BLINK_HALF + 2) begin
            @(negedge clk_in);
            seen[stop_led_out === 1'b1] = 1'b1;
        end
        `CHK(seen, on ? 2'b11 : 2'b01)
    endtask

    // values straight after reset, unmapped place
    task automatic t_reset();
        @(negedge clk_in);
        `CHK({run_out, outputs_off_out, irq_out, stop_led_out}, 4'h8)
        rdchk(8'h00, 32'h0);
        bus(1'b1, 8'h24, 32'hffff_ffff);
        rdchk(8'h24, 32'h0);
        $display("test reset done");
    endtask

    // warning list order, full list, release with refill, clear
    task automatic t_warn();
        bus(1'b1, 8'h18, 32'he);          // enable warning events
        bus(1'b1, 8'h80, 32'h400);        // warning 10
        scan();
        `CHK({warning_annunciation_bit_out, run_out, irq_out}, 3'h7)
        rdchk(8'h08, 32'h2);
        rdchk(8'h10, 32'h2);
        list_chk('{10, 0, 0, 0, 0, 0, 0, 0}, 1);
        blink_chk(1'b1);
        bus(1'b1, 8'h14, 32'h2);          // clear rise event
        rdchk(8'h10, 32'h0);
        bus(1'b1, 8'h80, 32'h840e);       // 1 2 3 10 15
        bus(1'b1, 8'h84, 32'h1004_0100);  // 40 50 60
        bus(1'b1, 8'h88, 32'h800);        // 75
        rdchk(8'h88, 32'h800);
        scan();
        list_chk('{10, 1, 2, 3, 15, 40, 50, 60}, 8);
        rdchk(8'h10, 32'h8);
        bus(1'b1, 8'h80, 32'h800e);       // release 10
        scan();
        list_chk('{1, 2, 3, 15, 40, 50, 60, 75}, 8);
        bus(1'b1, 8'h80, 32'h0);
        bus(1'b1, 8'h84, 32'h0);
        bus(1'b1, 8'h88, 32'h0);
        scan();
        `CHK(warning_annunciation_bit_out, 1'b0)
        list_chk('{0, 0, 0, 0, 0, 0, 0, 0}, 0);
        rdchk(8'h10, 32'hc);
        blink_chk(1'b0);
        $display("test warn done");
    endtask

    // fatal code in one slot, persistence, reset
    task automatic t_fault(input logic [3:0] slot, input logic [31:0] code);
        logic [7:0] a;
        a = 8'h40 + {2'b00, slot, 2'b00};
        do_reset();
        bus(1'b1, 8'h18, 32'h1);          // enable fatal event
        bus(1'b1, a, code);
        rdchk(a, code);
        `CHK(fault_annunciation_bit_out, 1'b0)
        scan();
        `CHK({fault_annunciation_bit_out, outputs_off_out, run_out, irq_out}, 4'hd)
        rdchk(8'h04, 32'h1);
        blink_chk(1'b1);
        bus(1'b1, a, 32'h0);
        scan();
        `CHK({outputs_off_out, run_out}, 2'b10)
        do_reset();
        @(negedge clk_in);
        `CHK({outputs_off_out, run_out}, 2'b01)
        $display("test fault done");
    endtask

    // verdict and end of run
    task automatic results();
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_warn();
        t_fault(4'd0, 32'h1);
        t_fault(4'd15, 32'hffff);
        results();
    end

    // watchdog, well beyond the expected run of under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_in);
        failures++;
        results();
    end
endmodule
